// *** bench/rpf_filter_props.sv ***
// rpf_filter_props: port assertions on rpf_filter
// assumes one clk domain, nrst async active low
`timescale 1ns/1ps
`default_nettype none
module rpf_filter_props
	import rpf_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [RPF_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_data_valid,
	input wire logic sync_hit,
	input wire logic pkt_done,
	input wire logic pkt_drop,
	input wire logic pin_drive_strength
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_ready_now: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	a_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	a_upper_zero: assert property (psel && penable |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_err_reads_zero: assert property (psel && penable && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_drive_copy: assert property (psel && penable && pwrite && pstrb[0]
		&& paddr == {RPF_IDX_TOUT_B, 2'b00} |=> ##1 pin_drive_strength == $past(pwdata[7], 2))
		else $error("drive strength not bit 7");
	// bits may arrive every cycle, so a length byte needs eight more cycles
	a_sync_quiet: assert property (sync_hit |=> !rx_data_valid [*6])
		else $error("byte too soon after sync");
	a_drop_alone: assert property (pkt_drop |-> !pkt_done)
		else $error("dropped packet also done");
	a_sync_single: assert property (sync_hit |=> !sync_hit)
		else $error("sync pulse too long");
endmodule // rpf_filter_props
`default_nettype wire

// *** bench/rpf_radio_model.sv ***
// rpf_radio_model: demodulator side, serial bits msb first plus status levels
// assumes caller enters send right after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module rpf_radio_model (
	input wire logic clk,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic [7:0] rssi,
	output logic [6:0] link_quality_indicator,
	output logic crc_ok
);
	initial begin
		rx_bit_valid = 1'b0;
		rx_bit = 1'b0;
		rssi = 8'ha5;
		link_quality_indicator = 7'h33;
		crc_ok = 1'b1;
	end
	// between bits the data line shows the inverse, never a stale copy
	task automatic send(input logic [7:0] b, input int g);
		for (int i = 7; i >= 0; i--) begin
			rx_bit_valid <= 1'b1;
			rx_bit <= b[i];
			@(posedge clk);
			if (g > 0) begin
				rx_bit_valid <= 1'b0;
				rx_bit <= ~b[i];
				repeat (g) @(posedge clk);
			end
		end
	endtask
	task automatic idle();
		rx_bit_valid <= 1'b0;
		rx_bit <= ~rx_bit;
	endtask
endmodule // rpf_radio_model
`default_nettype wire

// *** bench/tb.sv ***
// tb: self-checking bench for rpf_filter
// assumes rpf_radio_model supplies the bit stream
`timescale 1ns/1ps
`default_nettype none
module tb
	import rpf_pkg::*;
;
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [RPF_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic [3:0] pstrb = 4'h1;
	logic pready, pslverr, rx_bit_valid, rx_bit, crc_ok, rx_data_valid, sync_hit;
	logic pkt_done, pkt_drop, port1_pin7, port1_pin6, port1_pin5, pin_drive_strength;
	logic [7:0] rssi, rx_data;
	logic [6:0] link_quality_indicator;
	logic [63:0] dbg_sig = 64'h20;
	logic [8:0] got[$];
	int num_errors = 0, tests_run = 0, n_sync, n_drop;
	always #25 clk = ~clk;
	rpf_filter rpf_filter_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.rssi(rssi), .link_quality_indicator(link_quality_indicator), .crc_ok(crc_ok),
		.dbg_sig(dbg_sig), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
		.sync_hit(sync_hit), .pkt_done(pkt_done), .pkt_drop(pkt_drop),
		.port1_pin7(port1_pin7), .port1_pin6(port1_pin6), .port1_pin5(port1_pin5),
		.pin_drive_strength(pin_drive_strength));
	rpf_radio_model rpf_radio_model_i (.clk, .rx_bit_valid, .rx_bit, .rssi,
		.link_quality_indicator, .crc_ok);
	always @(posedge clk) begin
		if (rx_data_valid === 1'b1) got.push_back({pkt_done, rx_data});
		n_sync += (sync_hit === 1'b1);
		n_drop += (pkt_drop === 1'b1);
	end
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] x);
		apb(1'b0, i, 8'h00);
		chk("reg_read", {24'h0, x}, r);
	endtask
	// stale counter is floored by the zero bytes ahead of every sync
	task automatic pkt(input logic [7:0] b[$], input int g);
		logic [7:0] q[$];
		q = {8'h00, 8'h00, 8'haa, 8'h55, b};
		got = {};
		n_sync = 0;
		n_drop = 0;
		@(posedge clk);
		foreach (q[k]) rpf_radio_model_i.send(q[k], g);
		rpf_radio_model_i.idle();
		repeat (6) @(posedge clk);
	endtask
	task automatic t_reset();
		logic [15:0] i[9] = '{RPF_IDX_SYNC_HI, RPF_IDX_SYNC_LO, RPF_IDX_SIZE_LIM,
			RPF_IDX_FILT_CTL, RPF_IDX_DEV_ADDR, RPF_IDX_TOUT_C, RPF_IDX_TOUT_B,
			RPF_IDX_TOUT_A, RPF_IDX_MODE};
		logic [7:0] x[9] = '{8'hd3, 8'h91, 8'hff, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		foreach (i[k]) rd(i[k], x[k]);
		apb(1'b0, 16'h0001, 8'h00);
		chk("unmapped_err", 1, e);
	endtask
	task automatic t_regs();
		logic [15:0] i[4] = '{RPF_IDX_FILT_CTL, RPF_IDX_TOUT_C, RPF_IDX_TOUT_B, RPF_IDX_TOUT_A};
		logic [7:0] x[4] = '{8'he7, 8'h7f, 8'hff, 8'h7f};
		foreach (i[k]) apb(1'b1, i[k], 8'hff);
		foreach (i[k]) rd(i[k], x[k]);
		pstrb <= 4'h0;
		apb(1'b1, RPF_IDX_DEV_ADDR, 8'h55);
		pstrb <= 4'h1;
		rd(RPF_IDX_DEV_ADDR, 8'h00);
		apb(1'b1, RPF_IDX_TOUT_A, 8'h05);
		apb(1'b1, RPF_IDX_TOUT_C, 8'h45);
		apb(1'b1, RPF_IDX_TOUT_B, 8'hc4);
		repeat (2) @(posedge clk);
		chk("pin5", 1, port1_pin5);
		chk("pin7", 0, port1_pin7);
		chk("pin6", 1, port1_pin6);
		chk("drive", 1, pin_drive_strength);
	endtask
	task automatic t_rx();
		logic [8:0] x[5] = '{9'h002, 9'h03c, 9'h07e, 9'h0a5, 9'h1b3};
		logic [7:0] a[4] = '{8'h3c, 8'h00, 8'hff, 8'h11};
		logic ok;
		apb(1'b1, RPF_IDX_SYNC_HI, 8'haa);
		apb(1'b1, RPF_IDX_SYNC_LO, 8'h55);
		apb(1'b1, RPF_IDX_DEV_ADDR, 8'h3c);
		apb(1'b1, RPF_IDX_FILT_CTL, 8'h05);
		pkt({8'h02, 8'h3c, 8'h7e}, 1);
		chk("sync_cnt", 1, n_sync);
		chk("byte_cnt", 5, got.size());
		foreach (x[k]) chk("rx_byte", x[k], got[k]);
		for (int m = 0; m < 4; m++) for (int k = 0; k < 4; k++) begin
			apb(1'b1, RPF_IDX_FILT_CTL, 8'(m));
			pkt({8'h02, a[k], 8'h7e}, 0);
			ok = m == 0 || k == 0 || (k == 1 && m > 1) || (k == 2 && m == 3);
			chk("addr_ok", ok, got.size() == 3 && got[2] == 9'h17e);
			chk("addr_drop", !ok, n_drop);
		end
		apb(1'b1, RPF_IDX_FILT_CTL, 8'h00);
		apb(1'b1, RPF_IDX_SIZE_LIM, 8'h01);
		pkt({8'h02, 8'h3c, 8'h7e}, 0);
		chk("len_drop", 1, n_drop);
		apb(1'b1, RPF_IDX_SIZE_LIM, 8'h02);
		pkt({8'h02, 8'h3c, 8'h7e}, 0);
		chk("len_edge", 9'h17e, got[$]);
		apb(1'b1, RPF_IDX_MODE, 8'h01);
		pkt({8'h3c, 8'h7e}, 0);
		chk("fixed", {9'h03c, 9'h17e}, {got[0], got[1]});
		apb(1'b1, RPF_IDX_MODE, 8'h00);
		apb(1'b1, RPF_IDX_FILT_CTL, 8'h40);
		pkt({8'h02, 8'h3c, 8'h7e}, 0);
		chk("pq_block", 0, n_sync);
		apb(1'b1, RPF_IDX_FILT_CTL, 8'h20);
		pkt({8'h02, 8'h3c, 8'h7e}, 0);
		chk("pq_pass", 1, n_sync);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_regs();
		t_rx();
		print_verdict();
	end
	// run needs about 1600 cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		print_verdict();
	end
endmodule // tb
bind rpf_filter rpf_filter_props rpf_filter_props_i (.clk, .nrst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_data_valid,
	.sync_hit, .pkt_done, .pkt_drop, .pin_drive_strength);
`default_nettype wire

// *** hw/rpf_filter.sv ***
// rpf_filter: radio packet filter configuration, sync hunt, length and address filtering
// assumes rx bits arrive synchronous to clk, one per rx_bit_valid pulse, msb first
`timescale 1ns/1ps
`default_nettype none

module rpf_filter
	import rpf_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [RPF_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic [7:0] rssi,
	input wire logic [6:0] link_quality_indicator,
	input wire logic crc_ok,
	input wire logic [63:0] dbg_sig,
	output logic [7:0] rx_data,
	output logic rx_data_valid,
	output logic sync_hit,
	output logic pkt_done,
	output logic pkt_drop,
	output logic port1_pin7,
	output logic port1_pin6,
	output logic port1_pin5,
	output logic pin_drive_strength
);

	typedef struct packed {
		// software visible configuration
		logic [7:0] sync_hi;
		logic [7:0] sync_lo;
		logic [7:0] size_lim;
		logic [7:0] filt_ctl;
		logic [7:0] dev_addr;
		logic [7:0] mode_ctl;
		logic [2:0][7:0] tcfg;

		// apb read capture
		logic [15:0] rdata;
		logic rerr;

		// sync hunt and byte framing
		logic [15:0] shreg;
		logic prev_bit;
		logic [7:0] pq_cnt;
		rpf_state_e st;
		logic [2:0] bit_cnt;
		logic [7:0] byte_sh;
		logic [7:0] remain;
		logic first;

		// registered outputs
		logic [7:0] rx_data;
		logic rx_valid;
		logic sync_hit;
		logic pkt_done;
		logic pkt_drop;

		// test pins lag their config by one cycle
		logic [2:0] tout;
		logic drv;
	} rpf_regs_s;

	rpf_regs_s r;
	rpf_regs_s next_r;

	// misaligned or unknown addresses decode to none
	function automatic rpf_reg_e reg_decode(input logic [RPF_AW-1:0] a);
		logic [RPF_IW-1:0] idx;
		idx = a[RPF_AW-1:2];
		if (a[1:0] != 2'h0) begin
			return RPF_R_NONE;
		end
		unique case (idx)
			RPF_IDX_SYNC_HI: return RPF_R_SYNC_HI;
			RPF_IDX_SYNC_LO: return RPF_R_SYNC_LO;
			RPF_IDX_SIZE_LIM: return RPF_R_SIZE_LIM;
			RPF_IDX_FILT_CTL: return RPF_R_FILT_CTL;
			RPF_IDX_DEV_ADDR: return RPF_R_DEV_ADDR;
			RPF_IDX_TOUT_C: return RPF_R_TOUT_C;
			RPF_IDX_TOUT_B: return RPF_R_TOUT_B;
			RPF_IDX_TOUT_A: return RPF_R_TOUT_A;
			RPF_IDX_MODE: return RPF_R_MODE;
			RPF_IDX_STATUS: return RPF_R_STATUS;
			default: return RPF_R_NONE;
		endcase
	endfunction

	// saturating quality counter step
	function automatic logic [7:0] pq_step(input logic [7:0] c, input logic same);
		logic [7:0] n;
		n = c;
		if (same) begin
			// floor at zero: a long run of equal bits must not wrap
			if (c > RPF_PQ_DEC) begin
				n = c - RPF_PQ_DEC;
			end else begin
				n = 8'h00;
			end
		end else if (c != RPF_PQ_MAX) begin
			n = c + RPF_PQ_INC;
		end
		return n;
	endfunction

	// own address always passes; broadcast codes only as the mode allows
	function automatic logic addr_ok(input logic [1:0] m, input logic [7:0] b,
			input logic [7:0] own);
		logic hit;
		logic bc_lo;
		logic bc_hi;
		hit = (b == own);
		bc_lo = (b == RPF_BCAST_LO);
		bc_hi = (b == RPF_BCAST_HI);
		unique case (m)
			RPF_ADR_OFF: begin
				hit = 1'b1;
			end
			RPF_ADR_NOBC: begin
				hit = hit;
			end
			RPF_ADR_BC0: begin
				hit = hit || bc_lo;
			end
			RPF_ADR_BC0FF: begin
				hit = hit || bc_lo || bc_hi;
			end
		endcase
		return hit;
	endfunction

	// one test pin: selected internal signal, optionally inverted
	function automatic logic tout_level(input logic [7:0] cfg, input logic [63:0] sigs);
		logic lvl;
		lvl = sigs[cfg[RPF_SEL_MSB:0]];
		return lvl ^ cfg[RPF_INV_BIT];
	endfunction

	rpf_reg_e acc_reg;
	logic [1:0] adr_mode;
	logic [2:0] preamble_quality_threshold;
	logic append;
	logic [7:0] new_byte;
	logic [15:0] new_sh;
	logic pq_pass;
	logic sync_seen;

	assign acc_reg = reg_decode(paddr);
	assign adr_mode = r.filt_ctl[RPF_ADR_MSB:0];
	assign preamble_quality_threshold = r.filt_ctl[RPF_PQT_MSB:RPF_PQT_LSB];
	assign append = r.filt_ctl[RPF_APPEND_BIT];
	assign new_byte = {r.byte_sh[6:0], rx_bit};
	assign new_sh = {r.shreg[14:0], rx_bit};
	// threshold zero bypasses the gate entirely
	assign pq_pass = (preamble_quality_threshold == 3'h0) || (r.pq_cnt >= {3'h0, preamble_quality_threshold, 2'h0});
	assign sync_seen = (new_sh == {r.sync_hi, r.sync_lo});

	always_comb begin
		next_r = r;
		next_r.rx_valid = 1'b0;
		next_r.sync_hit = 1'b0;
		next_r.pkt_done = 1'b0;
		next_r.pkt_drop = 1'b0;

		// read data captured in the setup phase so prdata comes from flops
		if (psel && !penable) begin
			next_r.rerr = (acc_reg == RPF_R_NONE);
			unique case (acc_reg)
				RPF_R_SYNC_HI: next_r.rdata = {8'h00, r.sync_hi};
				RPF_R_SYNC_LO: next_r.rdata = {8'h00, r.sync_lo};
				RPF_R_SIZE_LIM: next_r.rdata = {8'h00, r.size_lim};
				RPF_R_FILT_CTL: next_r.rdata = {8'h00, r.filt_ctl};
				RPF_R_DEV_ADDR: next_r.rdata = {8'h00, r.dev_addr};
				RPF_R_TOUT_C: next_r.rdata = {8'h00, r.tcfg[2]};
				RPF_R_TOUT_B: next_r.rdata = {8'h00, r.tcfg[1]};
				RPF_R_TOUT_A: next_r.rdata = {8'h00, r.tcfg[0]};
				RPF_R_MODE: next_r.rdata = {8'h00, r.mode_ctl};
				RPF_R_STATUS: next_r.rdata = {5'h00, r.st, r.pq_cnt};
				RPF_R_NONE: next_r.rdata = 16'h0000;
			endcase
		end

		// only byte lane 0 carries register data
		if (psel && penable && pwrite && pstrb[0]) begin
			unique case (acc_reg)
				RPF_R_SYNC_HI: next_r.sync_hi = pwdata[7:0];
				RPF_R_SYNC_LO: next_r.sync_lo = pwdata[7:0];
				RPF_R_SIZE_LIM: next_r.size_lim = pwdata[7:0];
				RPF_R_FILT_CTL: next_r.filt_ctl = pwdata[7:0] & RPF_MSK_FILT_CTL;
				RPF_R_DEV_ADDR: next_r.dev_addr = pwdata[7:0];
				RPF_R_TOUT_C: next_r.tcfg[2] = pwdata[7:0] & RPF_MSK_TOUT_AC;
				RPF_R_TOUT_B: next_r.tcfg[1] = pwdata[7:0] & RPF_MSK_TOUT_B;
				RPF_R_TOUT_A: next_r.tcfg[0] = pwdata[7:0] & RPF_MSK_TOUT_AC;
				RPF_R_MODE: next_r.mode_ctl = pwdata[7:0] & RPF_MSK_MODE;
				RPF_R_STATUS: next_r.mode_ctl = r.mode_ctl;
				RPF_R_NONE: next_r.mode_ctl = r.mode_ctl;
			endcase
		end

		// receive bit path
		if (rx_bit_valid) begin
			next_r.prev_bit = rx_bit;
			next_r.byte_sh = new_byte;
			next_r.bit_cnt = r.bit_cnt + 3'h1;
			unique case (r.st)
				RPF_HUNT: begin
					next_r.shreg = new_sh;
					next_r.pq_cnt = pq_step(r.pq_cnt, rx_bit == r.prev_bit);
					// quality gate compares the count before this bit
					if (sync_seen && pq_pass) begin
						next_r.sync_hit = 1'b1;
						next_r.pq_cnt = 8'h00;
						next_r.shreg = 16'h0000;
						next_r.bit_cnt = 3'h0;
						next_r.first = 1'b1;
						next_r.remain = r.size_lim;
						if (!r.mode_ctl[RPF_FIXED_BIT]) begin
							next_r.st = RPF_LEN;
						end else if (r.size_lim == 8'h00) begin
							next_r.st = append ? RPF_STAT1 : RPF_HUNT;
							next_r.pkt_done = !append;
						end else begin
							next_r.st = RPF_PAYLOAD;
						end
					end
				end
				RPF_LEN: begin
					if (r.bit_cnt == RPF_LAST_BIT) begin
						// an oversize length drops the frame before any payload
						next_r.rx_data = new_byte;
						if (new_byte > r.size_lim) begin
							next_r.pkt_drop = 1'b1;
							next_r.st = RPF_HUNT;
						end else if (new_byte == 8'h00) begin
							next_r.rx_valid = 1'b1;
							next_r.st = append ? RPF_STAT1 : RPF_HUNT;
							next_r.pkt_done = !append;
						end else begin
							next_r.rx_valid = 1'b1;
							next_r.remain = new_byte;
							next_r.st = RPF_PAYLOAD;
						end
					end
				end
				RPF_PAYLOAD: begin
					if (r.bit_cnt == RPF_LAST_BIT) begin
						next_r.first = 1'b0;
						next_r.remain = r.remain - 8'h01;
						next_r.rx_data = new_byte;
						if (r.first && !addr_ok(adr_mode, new_byte, r.dev_addr)) begin
							next_r.pkt_drop = 1'b1;
							next_r.st = RPF_HUNT;
						end else begin
							next_r.rx_valid = 1'b1;
							if (r.remain == 8'h01) begin
								next_r.st = append ? RPF_STAT1 : RPF_HUNT;
								next_r.pkt_done = !append;
							end
						end
					end
				end
				default: next_r.st = r.st;
			endcase
		end

		// status bytes follow on consecutive cycles; incoming bits are ignored
		if (r.st == RPF_STAT1) begin
			next_r.rx_data = rssi;
			next_r.rx_valid = 1'b1;
			next_r.st = RPF_STAT2;
		end else if (r.st == RPF_STAT2) begin
			next_r.rx_data = {crc_ok, link_quality_indicator};
			next_r.rx_valid = 1'b1;
			next_r.pkt_done = 1'b1;
			next_r.st = RPF_HUNT;
		end

		// test outputs and pin drive
		for (int i = 0; i < 3; i++) begin
			next_r.tout[i] = tout_level(r.tcfg[i], dbg_sig);
		end
		next_r.drv = r.tcfg[1][RPF_DS_BIT];
	end

	// reset loads register defaults; everything else clears
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.sync_hi <= RPF_RST_SYNC_HI;
			r.sync_lo <= RPF_RST_SYNC_LO;
			r.size_lim <= RPF_RST_SIZE_LIM;
			r.filt_ctl <= RPF_RST_FILT_CTL;
			r.dev_addr <= RPF_RST_DEV_ADDR;
			r.mode_ctl <= RPF_RST_MODE;
			r.tcfg <= {RPF_RST_TOUT, RPF_RST_TOUT, RPF_RST_TOUT};
			r.st <= RPF_HUNT;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = {16'h0000, r.rdata};
	assign pready = psel & penable;
	assign pslverr = psel & penable & r.rerr;
	assign rx_data = r.rx_data;
	assign rx_data_valid = r.rx_valid;
	assign sync_hit = r.sync_hit;
	assign pkt_done = r.pkt_done;
	assign pkt_drop = r.pkt_drop;
	assign port1_pin5 = r.tout[0];
	assign port1_pin6 = r.tout[1];
	assign port1_pin7 = r.tout[2];
	assign pin_drive_strength = r.drv;

endmodule // rpf_filter

`default_nettype wire

// *** hw/rpf_pkg.sv ***
// rpf_pkg: constants, register indices and state codes of the radio packet filter
// assumes 32-bit apb; byte address of a register is four times its index
package rpf_pkg;

	localparam int RPF_AW = 18;
	localparam int RPF_IW = 16;

	// register indices; byte address = index * 4
	localparam logic [RPF_IW-1:0] RPF_IDX_SYNC_HI = 16'hdf00;
	localparam logic [RPF_IW-1:0] RPF_IDX_SYNC_LO = 16'hdf01;
	localparam logic [RPF_IW-1:0] RPF_IDX_SIZE_LIM = 16'hdf02;
	localparam logic [RPF_IW-1:0] RPF_IDX_FILT_CTL = 16'hdf03;
	localparam logic [RPF_IW-1:0] RPF_IDX_DEV_ADDR = 16'hdf05;
	localparam logic [RPF_IW-1:0] RPF_IDX_TOUT_C = 16'hdf2f;
	localparam logic [RPF_IW-1:0] RPF_IDX_TOUT_B = 16'hdf30;
	localparam logic [RPF_IW-1:0] RPF_IDX_TOUT_A = 16'hdf31;
	localparam logic [RPF_IW-1:0] RPF_IDX_MODE = 16'hdf40;
	localparam logic [RPF_IW-1:0] RPF_IDX_STATUS = 16'hdf41;

	// reset values
	localparam logic [7:0] RPF_RST_SYNC_HI = 8'hd3;
	localparam logic [7:0] RPF_RST_SYNC_LO = 8'h91;
	localparam logic [7:0] RPF_RST_SIZE_LIM = 8'hff;
	localparam logic [7:0] RPF_RST_FILT_CTL = 8'h04;
	localparam logic [7:0] RPF_RST_DEV_ADDR = 8'h00;
	localparam logic [7:0] RPF_RST_TOUT = 8'h00;
	localparam logic [7:0] RPF_RST_MODE = 8'h00;

	// writable bit masks; other bits read zero
	localparam logic [7:0] RPF_MSK_FILT_CTL = 8'he7;
	localparam logic [7:0] RPF_MSK_TOUT_AC = 8'h7f;
	localparam logic [7:0] RPF_MSK_TOUT_B = 8'hff;
	localparam logic [7:0] RPF_MSK_MODE = 8'h01;

	// field positions
	localparam int RPF_SEL_MSB = 5;
	localparam int RPF_INV_BIT = 6;
	localparam int RPF_DS_BIT = 7;
	localparam int RPF_PQT_MSB = 7;
	localparam int RPF_PQT_LSB = 5;
	localparam int RPF_APPEND_BIT = 2;
	localparam int RPF_ADR_MSB = 1;
	localparam int RPF_FIXED_BIT = 0;

	// address filter modes
	localparam logic [1:0] RPF_ADR_OFF = 2'h0;
	localparam logic [1:0] RPF_ADR_NOBC = 2'h1;
	localparam logic [1:0] RPF_ADR_BC0 = 2'h2;
	localparam logic [1:0] RPF_ADR_BC0FF = 2'h3;
	localparam logic [7:0] RPF_BCAST_LO = 8'h00;
	localparam logic [7:0] RPF_BCAST_HI = 8'hff;

	// preamble quality counter steps
	localparam logic [7:0] RPF_PQ_INC = 8'h01;
	localparam logic [7:0] RPF_PQ_DEC = 8'h08;
	localparam logic [7:0] RPF_PQ_MAX = 8'hff;
	localparam logic [2:0] RPF_LAST_BIT = 3'h7;

	typedef enum logic [2:0] {
		RPF_HUNT = 3'b000,
		RPF_LEN = 3'b001,
		RPF_PAYLOAD = 3'b010,
		RPF_STAT1 = 3'b011,
		RPF_STAT2 = 3'b100
	} rpf_state_e;

	typedef enum logic [3:0] {
		RPF_R_NONE = 4'h0,
		RPF_R_SYNC_HI = 4'h1,
		RPF_R_SYNC_LO = 4'h2,
		RPF_R_SIZE_LIM = 4'h3,
		RPF_R_FILT_CTL = 4'h4,
		RPF_R_DEV_ADDR = 4'h5,
		RPF_R_TOUT_C = 4'h6,
		RPF_R_TOUT_B = 4'h7,
		RPF_R_TOUT_A = 4'h8,
		RPF_R_MODE = 4'h9,
		RPF_R_STATUS = 4'ha
	} rpf_reg_e;

endpackage
